// ### shared/sram_ctl_defs.svh
// Constants for the synchronous burst SRAM control block.
// Behaviour
// - Sleep high: all data lines high-impedance.
// - Read drives data only with output enable low.
// - Deselected device never drives data lines.
// - Write cycle turns drivers off regardless.
// - No decoded write means the cycle reads.
// - Undriven sleep input means normal operation.
// - Processor strobe start: load address, read.
// - Controller strobe start: load address, decode write.
// - Advance low: next address, continue burst.
// - Primary select high blocks processor strobe.
// - Advance high: hold address, repeat access.
// - Global, gate and lane write decode.
// - Burst order linear or interleaved by input.
// - Two-bit burst counter wraps after four.
// - Lane enables ignored on processor strobe edge.
// - Two-cycle wake-up after sleep ends.
`ifndef SRAM_CTL_DEFS_SVH
`define SRAM_CTL_DEFS_SVH

`define SRAM_ADDR_W        20
`define SRAM_LANES         4
`define SRAM_DATA_W        36
`define SRAM_NARROW_MASK   4'h3
`define SRAM_WIDE_MASK     4'hF
`define SRAM_WAKE_CYCLES   2

`define REG_CTRL_OFFSET    12'h000
`define REG_STATUS_OFFSET  12'h004
`define CTRL_NARROW_BIT    0
`define CTRL_SLEEP_BIT     1
`define CTRL_RESET         2'h0
`define STATUS_LANES_LSB   0
`define STATUS_COUNT_LSB   4
`define STATUS_WRITE_BIT   6
`define STATUS_LIVE_BIT    7
`define STATUS_STATE_LSB   8
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

// ### shared/sram_ctl_pkg.sv
// Types shared by the synchronous burst SRAM control block.
`include "sram_ctl_defs.svh"
package sram_ctl_pkg;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE  = 3'b100
    } power_state_t;

    typedef struct packed {
        logic                         valid;
        logic                         write;
        logic [`SRAM_LANES-1:0]       lanes;
        logic [`SRAM_ADDR_W-1:0]      addr;
    } mem_req_t;

endpackage

// ### design/sync_burst_sram_control.sv
// Control decode, burst counter, data gating and register slave for a pipelined burst SRAM.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "sram_ctl_defs.svh"
module sync_burst_sram_control
    import sram_ctl_pkg::*;
#(
    parameter int WAKE_CYCLES = `SRAM_WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // Memory bus control pins
    input  wire logic                      primary_select_n,
    input  wire logic [1:0]                secondary_select_pair,
    input  wire logic                      processor_address_strobe_n,
    input  wire logic                      controller_address_strobe_n,
    input  wire logic                      burst_advance_n,
    input  wire logic                      global_write_n,
    input  wire logic                      byte_write_gate_n,
    input  wire logic [`SRAM_LANES-1:0]    lane_write_n,
    input  wire logic                      burst_order_select,
    input  wire logic                      sleep_request,
    input  wire logic                      output_enable_n,
    input  wire logic [`SRAM_ADDR_W-1:0]   ext_addr,
    // Data pins, split into input, output and enable
    input  wire logic [`SRAM_DATA_W-1:0]   dq_in,
    output logic      [`SRAM_DATA_W-1:0]   dq_out,
    output logic                           dq_oe,
    // Memory array side
    output mem_req_t                       mem_req,
    output logic      [`SRAM_DATA_W-1:0]   mem_wdata,
    input  wire logic [`SRAM_DATA_W-1:0]   mem_rdata,
    // AXI4-Lite write channels
    input  wire logic [11:0]               s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic      [1:0]                s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [11:0]               s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic      [31:0]               s_axi_rdata,
    output logic      [1:0]                s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode functions.

    function automatic logic [1:0] burst_lo(input logic [1:0] start, input logic [1:0] step,
                                            input logic interleaved);
        logic [1:0] lo;
        lo = interleaved ? (start ^ step) : (start + step);
        return lo;
    endfunction

    function automatic logic [`SRAM_LANES-1:0] decode_lanes(input logic gw_n, input logic bw_n,
                                                            input logic [`SRAM_LANES-1:0] we_n,
                                                            input logic [`SRAM_LANES-1:0] mask);
        logic [`SRAM_LANES-1:0] lanes;
        if (!gw_n) begin
            lanes = mask;
        end else if (!bw_n) begin
            lanes = ~we_n & mask;
        end else begin
            lanes = '0;
        end
        return lanes;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    power_state_t                state;
    logic [1:0]                  wake_cnt;
    logic                        burst_live;
    logic                        cur_write;
    logic [1:0]                  burst_cnt;
    logic [1:0]                  start_lo;
    logic [`SRAM_ADDR_W-1:2]     addr_hi;
    logic [1:0]                  ctrl;
    logic [`SRAM_LANES-1:0]      last_lanes;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronous operation decode.

    // The sleep pin is honoured only when high; an undriven pin is held low outside the core.
    wire sleeping  = sleep_request || ctrl[`CTRL_SLEEP_BIT];
    wire run       = (state == ST_RUN) && !sleeping;
    wire sec_ok    = secondary_select_pair[0] && !secondary_select_pair[1];
    wire processor_address_strobe_n_lo   = !processor_address_strobe_n;
    wire controller_address_strobe_n_lo   = !controller_address_strobe_n;
    wire deselect  = (primary_select_n && controller_address_strobe_n_lo) ||
                     (!primary_select_n && !sec_ok && (processor_address_strobe_n_lo || controller_address_strobe_n_lo));
    wire begin_p   = !primary_select_n && sec_ok && processor_address_strobe_n_lo;
    wire begin_c   = !primary_select_n && sec_ok && !processor_address_strobe_n_lo && controller_address_strobe_n_lo;
    // With primary select high the processor strobe is treated as high.
    wire strobes_hi = !controller_address_strobe_n_lo && (!processor_address_strobe_n_lo || primary_select_n);
    wire cont      = strobes_hi && !burst_advance_n && burst_live;
    wire susp      = strobes_hi && burst_advance_n && burst_live;

    wire [`SRAM_LANES-1:0] lane_mask = ctrl[`CTRL_NARROW_BIT] ? `SRAM_NARROW_MASK : `SRAM_WIDE_MASK;
    wire [`SRAM_LANES-1:0] lanes_dec = decode_lanes(global_write_n, byte_write_gate_n,
                                                    lane_write_n, lane_mask);
    wire write_dec = |lanes_dec;
    // Lanes are not looked at on the processor strobe edge; that start is always a read.
    wire [`SRAM_LANES-1:0] op_lanes = begin_p ? '0 : lanes_dec;
    wire op_valid  = run && (begin_p || begin_c || cont || susp);
    wire op_write  = op_valid && (op_lanes != '0);

    wire [1:0] next_cnt = begin_p || begin_c ? 2'h0 : (cont ? burst_cnt + 2'h1 : burst_cnt);
    wire [1:0] next_start = (begin_p || begin_c) ? ext_addr[1:0] : start_lo;
    wire [`SRAM_ADDR_W-1:2] next_hi = (begin_p || begin_c) ? ext_addr[`SRAM_ADDR_W-1:2] : addr_hi;
    wire [1:0] next_lo = burst_lo(next_start, next_cnt, burst_order_select);
    wire next_live = (begin_p || begin_c) ? 1'b1 : (deselect ? 1'b0 : burst_live);

    // Data drivers follow the sampled access; writes, sleep and deselect all turn them off.
    wire next_oe = !sleeping && (state == ST_RUN) && burst_live && !cur_write
                   && !output_enable_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Power state and burst registers.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= ST_RUN;
            wake_cnt <= 2'h0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (sleeping) begin
                        state <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (!sleeping) begin
                        state    <= ST_WAKE;
                        wake_cnt <= 2'(WAKE_CYCLES - 1);
                    end
                end
                ST_WAKE: begin
                    if (sleeping) begin
                        state <= ST_SLEEP;
                    end else if (wake_cnt == 2'h0) begin
                        state <= ST_RUN;
                    end else begin
                        wake_cnt <= wake_cnt - 2'h1;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Burst context is preserved across sleep because nothing here updates outside run.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_live <= 1'b0;
            burst_cnt  <= 2'h0;
            start_lo   <= 2'h0;
            addr_hi    <= '0;
            cur_write  <= 1'b0;
            last_lanes <= '0;
        end else if (run) begin
            burst_live <= next_live;
            burst_cnt  <= next_cnt;
            start_lo   <= next_start;
            addr_hi    <= next_hi;
            if (op_valid) begin
                cur_write  <= op_write;
                last_lanes <= op_lanes;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_req   <= '0;
            mem_wdata <= '0;
            dq_out    <= '0;
            dq_oe     <= 1'b0;
        end else begin
            mem_req.valid <= op_valid && !deselect;
            mem_req.write <= op_write;
            mem_req.lanes <= op_valid ? op_lanes : '0;
            mem_req.addr  <= {next_hi, next_lo};
            mem_wdata     <= dq_in;
            dq_out        <= mem_rdata;
            dq_oe         <= next_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite register slave.

    logic        aw_got;
    logic        w_got;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    wire aw_hs   = s_axi_awvalid && s_axi_awready;
    wire w_hs    = s_axi_wvalid && s_axi_wready;
    wire do_wr   = aw_got && w_got && !s_axi_bvalid;
    wire wr_ctrl = (aw_addr == `REG_CTRL_OFFSET);
    wire [31:0] status_word = {21'h0, state, burst_live, cur_write, burst_cnt, last_lanes};
    wire [31:0] rd_word = (s_axi_araddr == `REG_CTRL_OFFSET)   ? {30'h0, ctrl} :
                          (s_axi_araddr == `REG_STATUS_OFFSET) ? status_word : 32'h0;
    wire rd_ok   = (s_axi_araddr == `REG_CTRL_OFFSET) || (s_axi_araddr == `REG_STATUS_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            ctrl          <= `CTRL_RESET;
        end else begin
            if (aw_hs) begin
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ctrl ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
                if (wr_ctrl && w_strb[0]) begin
                    ctrl <= w_data[1:0];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    property p_sleep_off;
        @(posedge aclk) disable iff (!aresetn)
        sleeping |=> !dq_oe;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("data driven during sleep");

    property p_oe_gate;
        @(posedge aclk) disable iff (!aresetn)
        output_enable_n |=> !dq_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("data driven with output enable high");

    property p_deselect_off;
        @(posedge aclk) disable iff (!aresetn)
        run && deselect |-> ##2 !dq_oe;
    endproperty
    a_deselect_off: assert property (p_deselect_off) else $error("deselected device drives data");

    property p_write_off;
        @(posedge aclk) disable iff (!aresetn)
        op_write && !sleeping |=> mem_req.write ##1 !dq_oe;
    endproperty
    a_write_off: assert property (p_write_off) else $error("drivers on during write");

    property p_no_write_read;
        @(posedge aclk) disable iff (!aresetn)
        run && !write_dec |=> !mem_req.write && (mem_req.lanes == '0);
    endproperty
    a_no_write_read: assert property (p_no_write_read) else $error("write without decode");

    property p_deselect;
        @(posedge aclk) disable iff (!aresetn)
        run && deselect |=> !mem_req.valid && !burst_live;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselect did not end access");

    property p_begin_read;
        @(posedge aclk) disable iff (!aresetn)
        run && begin_p |=> mem_req.valid && !mem_req.write && (mem_req.addr == $past(ext_addr));
    endproperty
    a_begin_read: assert property (p_begin_read) else $error("processor start not a read");

    property p_begin_ctrl;
        @(posedge aclk) disable iff (!aresetn)
        run && begin_c |=> (mem_req.addr == $past(ext_addr)) && (mem_req.write == $past(write_dec));
    endproperty
    a_begin_ctrl: assert property (p_begin_ctrl) else $error("controller start wrong");

    property p_continue;
        @(posedge aclk) disable iff (!aresetn)
        run && cont |=> burst_cnt == 2'($past(burst_cnt) + 2'h1);
    endproperty
    a_continue: assert property (p_continue) else $error("burst did not advance");

    property p_suspend;
        @(posedge aclk) disable iff (!aresetn)
        run && susp |=> $stable(burst_cnt) && $stable(start_lo) && mem_req.valid;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend moved the address");

    property p_global_write;
        @(posedge aclk) disable iff (!aresetn)
        run && !global_write_n && (begin_c || cont || susp) |=> mem_req.lanes == $past(lane_mask);
    endproperty
    a_global_write: assert property (p_global_write) else $error("global write not all lanes");

    property p_wake;
        @(posedge aclk) disable iff (!aresetn)
        state == ST_SLEEP && !sleeping |=> (state == ST_WAKE && !mem_req.valid)[*2] ##1 state == ST_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up not two cycles");

endmodule

// ### verif/bus_master_model.sv
// Processor-side memory bus master that drives the SRAM control pins.
`timescale 1ns/10ps
`include "sram_ctl_defs.svh"
module bus_master_model
    import sram_ctl_pkg::*;
(
    // Clock
    input  wire logic                     aclk,
    // Control pins
    output logic                          primary_select_n,
    output logic [1:0]                    secondary_select_pair,
    output logic                          processor_address_strobe_n,
    output logic                          controller_address_strobe_n,
    output logic                          burst_advance_n,
    output logic                          global_write_n,
    output logic                          byte_write_gate_n,
    output logic [`SRAM_LANES-1:0]        lane_write_n,
    output logic                          burst_order_select,
    output logic                          sleep_request,
    output logic                          output_enable_n,
    output logic [`SRAM_ADDR_W-1:0]       ext_addr,
    // Write data toward the pins
    output logic [`SRAM_DATA_W-1:0]       dq_in
);
    logic zz;
    logic oe_next;
    logic order;

    initial begin
        zz = 1'b0;
        oe_next = 1'b1;
        order = 1'b0;
        {primary_select_n, secondary_select_pair, processor_address_strobe_n,
            controller_address_strobe_n, burst_advance_n} = 6'h2D;
        {global_write_n, byte_write_gate_n, lane_write_n} = 6'h3F;
        burst_order_select = 1'b0;
        sleep_request = 1'b0;
        output_enable_n = 1'b1;
        ext_addr = 20'h00000;
        dq_in = 36'h000000000;
    end

    // One bus cycle: pins change just after the edge and hold until the next one.
    task automatic op(input logic [5:0] ctl, input logic [5:0] wr, input logic [19:0] a);
        @(posedge aclk);
        {primary_select_n, secondary_select_pair, processor_address_strobe_n,
            controller_address_strobe_n, burst_advance_n} <= ctl;
        {global_write_n, byte_write_gate_n, lane_write_n} <= wr;
        ext_addr <= a;
        sleep_request <= zz;
        output_enable_n <= oe_next;
        burst_order_select <= order;
        // Write data goes out only on a decoded write with outputs disabled; other cycles drive the inverse of the last value.
        dq_in <= (oe_next && (!wr[5] || (!wr[4] && wr[3:0] != 4'hF))) ? {16'h00D0, a} : ~dq_in;
        #1;
    endtask
endmodule

// ### verif/sync_burst_sram_control_tb_top.sv
// Self-checking testbench for the burst SRAM control block.
`timescale 1ns/10ps
`include "sram_ctl_defs.svh"
module sync_burst_sram_control_tb_top
    import sram_ctl_pkg::*;
;
    localparam logic [5:0]  START_P = 6'h0B, START_C = 6'h0D, NEXT = 6'h0E, HOLD = 6'h0F;
    localparam logic [5:0]  DESEL = 6'h2D, DESEL2 = 6'h03, NEXT_BLK = 6'h2A, RD = 6'h3F;
    localparam logic [19:0] A = 20'h12341;
    localparam logic [35:0] RDATA = 36'h9ABCD1234;
    localparam logic [5:0]  TC[8] = '{START_C, START_C, START_C, START_C, START_C, START_C, START_C, START_P};
    localparam logic [5:0]  TW[8] = '{6'h1F, 6'h30, 6'h2F, 6'h2E, 6'h2D, 6'h23, 6'h20, 6'h10};
    localparam logic        TE[8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    localparam logic [3:0]  TL[8] = '{4'hF, 4'h0, 4'h0, 4'h1, 4'h2, 4'hC, 4'hF, 4'h0};

    logic aclk, aresetn, primary_select_n, processor_address_strobe_n, controller_address_strobe_n;
    logic burst_advance_n, global_write_n, byte_write_gate_n, burst_order_select, sleep_request;
    logic output_enable_n, dq_oe, s_axi_awready, s_axi_awvalid, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  secondary_select_pair, s_axi_bresp, s_axi_rresp, c;
    logic [3:0]  lane_write_n, s_axi_wstrb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [19:0] ext_addr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [35:0] dq_in, dq_out, mem_wdata, mem_rdata;
    mem_req_t    mem_req;
    int          fails = 0;
    int          checks = 0;

    sync_burst_sram_control dut (.aclk, .aresetn, .primary_select_n, .secondary_select_pair,
        .processor_address_strobe_n, .controller_address_strobe_n, .burst_advance_n, .global_write_n,
        .byte_write_gate_n, .lane_write_n, .burst_order_select, .sleep_request, .output_enable_n, .ext_addr,
        .dq_in, .dq_out, .dq_oe, .mem_req, .mem_wdata, .mem_rdata, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    bus_master_model bm (.aclk, .primary_select_n, .secondary_select_pair, .processor_address_strobe_n,
        .controller_address_strobe_n, .burst_advance_n, .global_write_n, .byte_write_gate_n, .lane_write_n,
        .burst_order_select, .sleep_request, .output_enable_n, .ext_addr, .dq_in);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // The operation sampled one edge earlier shows on mem_req now.
    task automatic req(input logic v, input logic w, input logic [3:0] ln, input logic [19:0] ad);
        chk("valid", 36'(v), 36'(mem_req.valid));
        if (v) begin
            chk("write", 36'(w), 36'(mem_req.write));
            chk("addr", 36'(ad), 36'(mem_req.addr));
            if (w)
                chk("lanes", 36'(ln), 36'(mem_req.lanes));
        end
    endtask

    // Waits as long as the slave needs; only the watchdog ends a hung transfer.
    task automatic axw(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 36'(er), 36'(s_axi_bresp));
    endtask

    task automatic axr(input logic [11:0] ad, output logic [31:0] dt, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        dt = s_axi_rdata;
        chk("rresp", 36'(er), 36'(s_axi_rresp));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // The whole sequence needs well under two thousand cycles.
    initial begin
        #200000;
        fails++;
        results();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        mem_rdata = RDATA;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk("dq_oe", 36'h0, 36'(dq_oe));
        axr(`REG_CTRL_OFFSET, d, `AXI_RESP_OKAY);
        chk("ctrl", 36'h0, 36'(d));
        axr(`REG_STATUS_OFFSET, d, `AXI_RESP_OKAY);
        chk("state", 36'h1, 36'(d[10:8]));
        axr(12'h010, d, `AXI_RESP_SLVERR);
        chk("unmapped", 36'h0, 36'(d));
        axw(`REG_STATUS_OFFSET, 32'hFFFFFFFF, `AXI_RESP_SLVERR);
        bm.oe_next = 1'b0;
        for (int o = 0; o < 2; o++) begin
            bm.order = o[0];
            bm.op(START_P, RD, A);
            for (int k = 0; k < 6; k++) begin
                bm.op(k < 4 ? NEXT : HOLD, RD, A);
                c = (k > 3) ? 2'h0 : k[1:0];
                req(1'b1, 1'b0, 4'h0, {A[19:2], o[0] ? A[1:0] ^ c : A[1:0] + c});
                if (k == 3) begin
                    chk("dq_oe", 36'h1, 36'(dq_oe));
                    chk("dq_out", RDATA, dq_out);
                end
            end
        end
        repeat (3) bm.op(DESEL, RD, A);
        chk("dq_oe", 36'h0, 36'(dq_oe));
        bm.oe_next = 1'b1;
        bm.op(START_P, RD, A);
        repeat (3) bm.op(HOLD, RD, A);
        chk("dq_oe", 36'h0, 36'(dq_oe));
        bm.oe_next = 1'b0;
        for (int i = 0; i < 9; i++) begin
            bm.op(i < 8 ? TC[i] : DESEL, i < 8 ? TW[i] : RD, A);
            if (i > 0)
                req(1'b1, TE[i-1], TL[i-1], A);
            if (i == 7)
                chk("dq_oe", 36'h0, 36'(dq_oe));
        end
        axw(`REG_CTRL_OFFSET, 32'h00000001, `AXI_RESP_OKAY);
        axr(`REG_CTRL_OFFSET, d, `AXI_RESP_OKAY);
        chk("ctrl", 36'h1, 36'(d));
        bm.order = 1'b0;
        // Output enable is dropped here so the master really puts its write data on the lines.
        bm.oe_next = 1'b1;
        bm.op(START_C, 6'h1F, A);
        bm.op(DESEL, RD, A);
        req(1'b1, 1'b1, 4'h3, A);
        chk("mem_wdata", {16'h00D0, A}, mem_wdata);
        bm.oe_next = 1'b0;
        bm.op(NEXT, RD, A);
        req(1'b0, 1'b0, 4'h0, A);
        bm.op(DESEL2, RD, A);
        req(1'b0, 1'b0, 4'h0, A);
        bm.op(START_P, RD, A);
        req(1'b0, 1'b0, 4'h0, A);
        bm.op(NEXT_BLK, RD, A);
        req(1'b1, 1'b0, 4'h0, A);
        bm.op(HOLD, RD, A);
        req(1'b1, 1'b0, 4'h0, {A[19:2], 2'h2});
        bm.zz = 1'b1;
        repeat (4) bm.op(START_P, RD, A);
        req(1'b0, 1'b0, 4'h0, A);
        chk("dq_oe", 36'h0, 36'(dq_oe));
        bm.zz = 1'b0;
        bm.op(START_P, RD, A);
        bm.op(DESEL, RD, A);
        req(1'b0, 1'b0, 4'h0, A);
        repeat (2) bm.op(DESEL, RD, A);
        bm.op(START_P, RD, A);
        bm.op(HOLD, RD, A);
        req(1'b1, 1'b0, 4'h0, A);
        axw(`REG_CTRL_OFFSET, 32'h00000002, `AXI_RESP_OKAY);
        bm.op(START_P, RD, A);
        bm.op(HOLD, RD, A);
        req(1'b0, 1'b0, 4'h0, A);
        axr(`REG_STATUS_OFFSET, d, `AXI_RESP_OKAY);
        chk("state", 36'h2, 36'(d[10:8]));
        results();
    end
endmodule
